// ===== rtl/pab_reg_bank.sv
module pab_reg_bank #(
  parameter logic [15:0] ID_HI_VALUE = 16'hA5C3, // Arbitrary value
  parameter logic [15:0] ID_LO_VALUE = 16'h3C50 // Arbitrary value
) (
  input logic sys_clk,
  input logic srst,
  input logic pause_default_strap_pin,
  input logic reg_rd,
  input logic reg_wr,
  input logic [15:0] reg_addr,
  input logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_r,
  output logic reg_rvalid_r,
  input logic [4:0] lp_page_valid,
  input logic [4:0][15:0] lp_page_word,
  input logic [4:0] par_det_fault,
  input logic [4:0] lp_an_able,
  output logic [4:0][15:0] adv_word_r
);

  // All state of the bank
  typedef struct packed {
    logic [4:0][15:0] adv;
    logic [4:0][15:0] lpa;
    logic [4:0] pdf;
    logic [4:0] prx;
    logic [15:0] rdata;
    logic rvalid;
  } pab_state_s;

  pab_state_s s_r;
  pab_state_s s_nxt;
  pab_pkg::pab_reg_e sel;
  logic [2:0] idx;

  // Which register an address names; out-of-range ports map to none
  function automatic pab_pkg::pab_reg_e reg_decode(
    input logic [15:0] a
  );
    pab_pkg::pab_reg_e r;
    r = pab_pkg::PAB_REG_NONE;
    if (a[15:12] >= pab_pkg::PORT_FIRST &&
        a[15:12] <= pab_pkg::PORT_LAST) begin
      case (a[11:0])
        pab_pkg::OFF_ID_HI: r = pab_pkg::PAB_REG_ID_HI;
        pab_pkg::OFF_ID_LO: r = pab_pkg::PAB_REG_ID_LO;
        pab_pkg::OFF_ADV: r = pab_pkg::PAB_REG_ADV;
        pab_pkg::OFF_LPA: r = pab_pkg::PAB_REG_LPA;
        pab_pkg::OFF_EXP: r = pab_pkg::PAB_REG_EXP;
        default: r = pab_pkg::PAB_REG_NONE;
      endcase
    end
    return r;
  endfunction

  // Zero-based port index from the address nibble
  function automatic logic [2:0] port_index(input logic [15:0] a);
    logic [3:0] d;
    d = a[15:12] - pab_pkg::PORT_FIRST;
    return d[2:0];
  endfunction

  // Expansion status word of one port
  function automatic logic [15:0] exp_word(
    input logic pdf,
    input logic lp_np,
    input logic prx,
    input logic an_able
  );
    logic [15:0] w;
    w = 16'h0000;
    w[pab_pkg::EXP_PDF_BIT] = pdf;
    w[pab_pkg::EXP_LPNP_BIT] = lp_np;
    w[pab_pkg::EXP_NPA_BIT] = 1'b1;
    w[pab_pkg::EXP_PRX_BIT] = prx;
    w[pab_pkg::EXP_LPAN_BIT] = an_able;
    return w;
  endfunction

  assign sel = reg_decode(reg_addr);
  assign idx = port_index(reg_addr);

  // Next state: reset, partner capture, latched flags, host access
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.rdata = 16'h0000;
    if (srst) begin
      // Strap is read every reset cycle so the last one before release wins
      for (int p = 0; p < pab_pkg::NUM_PORTS; p++) begin
        s_nxt.adv[p] = pab_pkg::ADV_RST_BASE;
        s_nxt.adv[p][pab_pkg::ADV_PAUSE_MSB:pab_pkg::ADV_PAUSE_LSB] =
          {2{pause_default_strap_pin}};
        s_nxt.lpa[p] = 16'h0000;
      end
      s_nxt.pdf = 5'h00;
      s_nxt.prx = 5'h00;
    end else begin
      for (int p = 0; p < pab_pkg::NUM_PORTS; p++) begin
        // Whole received base page is kept, including ack and fault bits
        if (lp_page_valid[p]) begin
          s_nxt.lpa[p] = lp_page_word[p];
        end
        // Set beats the clear-on-read so no event is lost
        s_nxt.pdf[p] = par_det_fault[p] |
          (s_r.pdf[p] & ~(reg_rd && sel == pab_pkg::PAB_REG_EXP &&
           idx == 3'(p)));
        s_nxt.prx[p] = lp_page_valid[p] |
          (s_r.prx[p] & ~(reg_rd && sel == pab_pkg::PAB_REG_EXP &&
           idx == 3'(p)));
        // Read-only bits are masked so they can never be set by software
        if (reg_wr && sel == pab_pkg::PAB_REG_ADV && idx == 3'(p)) begin
          s_nxt.adv[p] = reg_wdata & pab_pkg::ADV_WR_MASK;
        end
      end
      // Read answer one cycle after the strobe; unmapped reads give zero
      if (reg_rd) begin
        s_nxt.rvalid = 1'b1;
        case (sel)
          pab_pkg::PAB_REG_ID_HI: s_nxt.rdata = ID_HI_VALUE;
          pab_pkg::PAB_REG_ID_LO: s_nxt.rdata = ID_LO_VALUE;
          pab_pkg::PAB_REG_ADV: s_nxt.rdata = s_r.adv[idx];
          pab_pkg::PAB_REG_LPA: s_nxt.rdata = s_r.lpa[idx];
          pab_pkg::PAB_REG_EXP: s_nxt.rdata = exp_word(s_r.pdf[idx],
            s_r.lpa[idx][pab_pkg::LPA_NP_BIT], s_r.prx[idx],
            lp_an_able[idx]);
          default: s_nxt.rdata = 16'h0000;
        endcase
      end
    end
  end

  // Single state register
  always_ff @(posedge sys_clk) begin
    s_r <= s_nxt;
  end

  // Outputs come straight from the state register
  assign reg_rdata_r = s_r.rdata;
  assign reg_rvalid_r = s_r.rvalid;
  assign adv_word_r = s_r.adv;

  // Checks on the bank
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_id_hi;
    reg_rd && reg_decode(reg_addr) == pab_pkg::PAB_REG_ID_HI
      |=> reg_rvalid_r && reg_rdata_r == ID_HI_VALUE;
  endproperty
  a_id_hi: assert property (p_id_hi)
    else $error("upper identifier read wrong");

  property p_id_lo;
    reg_rd && reg_decode(reg_addr) == pab_pkg::PAB_REG_ID_LO
      |=> reg_rvalid_r && reg_rdata_r == ID_LO_VALUE;
  endproperty
  a_id_lo: assert property (p_id_lo)
    else $error("lower identifier read wrong");

  property p_adv_reset;
    $past(srst) |-> adv_word_r[0] ==
      (pab_pkg::ADV_RST_BASE |
       ({16{$past(pause_default_strap_pin)}} & 16'h0C00));
  endproperty
  a_adv_reset: assert property (p_adv_reset)
    else $error("advertisement reset value wrong");

  property p_adv_ro_zero;
    (adv_word_r[4] & pab_pkg::ADV_RO_MASK) == 16'h0000;
  endproperty
  a_adv_ro_zero: assert property (p_adv_ro_zero)
    else $error("read-only advertisement bit set");

  property p_exp_read;
    reg_rd && reg_decode(reg_addr) == pab_pkg::PAB_REG_EXP
      |=> (reg_rdata_r & pab_pkg::EXP_RSVD_MASK) == 16'h0000 &&
          reg_rdata_r[pab_pkg::EXP_NPA_BIT] &&
          reg_rdata_r[pab_pkg::EXP_LPAN_BIT] ==
            $past(lp_an_able[port_index(reg_addr)]);
  endproperty
  a_exp_read: assert property (p_exp_read)
    else $error("expansion status read wrong");

  property p_unmapped;
    reg_rd && reg_decode(reg_addr) == pab_pkg::PAB_REG_NONE
      |=> reg_rvalid_r && reg_rdata_r == 16'h0000 ##1 !reg_rvalid_r ||
          $past(reg_rd);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  // Read-back paths: the answer is the state seen at the strobe edge,
  // so a read racing a write or an event returns the old value
  property p_adv_read;
    reg_rd && reg_decode(reg_addr) == pab_pkg::PAB_REG_ADV
      |=> reg_rdata_r == $past(adv_word_r[port_index(reg_addr)]);
  endproperty
  a_adv_read: assert property (p_adv_read)
    else $error("advertisement read-back wrong");

  property p_lpa_read;
    reg_rd && reg_decode(reg_addr) == pab_pkg::PAB_REG_LPA
      |=> reg_rdata_r == $past(s_r.lpa[port_index(reg_addr)]);
  endproperty
  a_lpa_read: assert property (p_lpa_read)
    else $error("partner ability read-back wrong");

  property p_exp_flags;
    reg_rd && reg_decode(reg_addr) == pab_pkg::PAB_REG_EXP
      |=> reg_rdata_r[pab_pkg::EXP_PDF_BIT] ==
            $past(s_r.pdf[port_index(reg_addr)]) &&
          reg_rdata_r[pab_pkg::EXP_PRX_BIT] ==
            $past(s_r.prx[port_index(reg_addr)]);
  endproperty
  a_exp_flags: assert property (p_exp_flags)
    else $error("expansion latched flags read wrong");

  property p_exp_lpnp;
    reg_rd && reg_decode(reg_addr) == pab_pkg::PAB_REG_EXP
      |=> reg_rdata_r[pab_pkg::EXP_LPNP_BIT] ==
            $past(s_r.lpa[port_index(reg_addr)][pab_pkg::LPA_NP_BIT]);
  endproperty
  a_exp_lpnp: assert property (p_exp_lpnp)
    else $error("partner next-page bit read wrong");

  // Per-port write, capture and latch checks
  for (genvar g = 0; g < pab_pkg::NUM_PORTS; g++) begin : g_chk
    logic exp_rd_g;
    assign exp_rd_g = reg_rd && sel == pab_pkg::PAB_REG_EXP &&
      idx == 3'(g);

    property p_adv_write;
      reg_wr && sel == pab_pkg::PAB_REG_ADV && idx == 3'(g)
        |=> adv_word_r[g] == ($past(reg_wdata) & pab_pkg::ADV_WR_MASK);
    endproperty
    a_adv_write: assert property (p_adv_write)
      else $error("advertisement write lost");

    property p_adv_hold;
      !(reg_wr && sel == pab_pkg::PAB_REG_ADV && idx == 3'(g))
        |=> $stable(adv_word_r[g]);
    endproperty
    a_adv_hold: assert property (p_adv_hold)
      else $error("advertisement changed without write");

    property p_lpa_capture;
      lp_page_valid[g] |=> s_r.lpa[g] == $past(lp_page_word[g]) &&
        s_r.prx[g];
    endproperty
    a_lpa_capture: assert property (p_lpa_capture)
      else $error("partner page not captured");

    property p_pdf_latch;
      par_det_fault[g] ##1 !par_det_fault[g] && !exp_rd_g
        |=> s_r.pdf[g];
    endproperty
    a_pdf_latch: assert property (p_pdf_latch)
      else $error("fault flag did not hold");

    property p_prx_clear;
      exp_rd_g && !lp_page_valid[g] |=> !s_r.prx[g];
    endproperty
    a_prx_clear: assert property (p_prx_clear)
      else $error("page flag not cleared by read");

    property p_set_wins;
      exp_rd_g && par_det_fault[g] |=> s_r.pdf[g];
    endproperty
    a_set_wins: assert property (p_set_wins)
      else $error("event lost during read");

    // Fixed reset fields; the pause pair is checked against the strap for port 0 only, in a_adv_reset
    property p_adv_reset_fields;
      $past(srst) |->
        !adv_word_r[g][pab_pkg::ADV_NP_BIT] &&
        !adv_word_r[g][pab_pkg::ADV_RF_BIT] &&
        adv_word_r[g][pab_pkg::ADV_ABIL_MSB:pab_pkg::ADV_ABIL_LSB] ==
          pab_pkg::ADV_ABIL_RST &&
        adv_word_r[g][pab_pkg::ADV_ABIL_LSB-1:0] == pab_pkg::ADV_SEL_8023;
    endproperty
    a_adv_reset_fields: assert property (p_adv_reset_fields)
      else $error("advertisement reset fields wrong");

    property p_prx_latch;
      lp_page_valid[g] ##1 !lp_page_valid[g] && !exp_rd_g
        |=> s_r.prx[g];
    endproperty
    a_prx_latch: assert property (p_prx_latch)
      else $error("page flag did not hold");

    property p_prx_set_wins;
      exp_rd_g && lp_page_valid[g] |=> s_r.prx[g];
    endproperty
    a_prx_set_wins: assert property (p_prx_set_wins)
      else $error("page lost during read");

    property p_pdf_clear;
      exp_rd_g && !par_det_fault[g] |=> !s_r.pdf[g];
    endproperty
    a_pdf_clear: assert property (p_pdf_clear)
      else $error("fault flag not cleared by read");

    // Partner word only moves on a page strobe
    property p_lpa_hold;
      !lp_page_valid[g] |=> $stable(s_r.lpa[g]);
    endproperty
    a_lpa_hold: assert property (p_lpa_hold)
      else $error("partner word changed without page");

    property p_adv_ro_port;
      (adv_word_r[g] & pab_pkg::ADV_RO_MASK) == 16'h0000;
    endproperty
    a_adv_ro_port: assert property (p_adv_ro_port)
      else $error("reserved advertisement bit set");
  end

  // Main scenarios
  c_adv_write: cover property (
    reg_wr && sel == pab_pkg::PAB_REG_ADV ##1
    reg_rd && sel == pab_pkg::PAB_REG_ADV);
  c_page_then_read: cover property (
    lp_page_valid[0] ##[1:4] reg_rd && sel == pab_pkg::PAB_REG_EXP);
  c_fault_on_read: cover property (
    reg_rd && sel == pab_pkg::PAB_REG_EXP && par_det_fault[idx]);
  c_unmapped: cover property (
    reg_rd && sel == pab_pkg::PAB_REG_NONE);
  c_strap_pause: cover property (
    $fell(srst) && adv_word_r[0][pab_pkg::ADV_PAUSE_MSB]);

endmodule // pab_reg_bank

// ===== include/pab_pkg.sv
package pab_pkg;

  // Bank shape
  localparam int NUM_PORTS = 5;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int IDX_W = 3;

  // Port number sits in the top nibble of the address
  localparam logic [3:0] PORT_FIRST = 4'h1;
  localparam logic [3:0] PORT_LAST = 4'h5;

  // Register offsets inside one port window
  localparam logic [11:0] OFF_ID_HI = 12'h104;
  localparam logic [11:0] OFF_ID_LO = 12'h106;
  localparam logic [11:0] OFF_ADV = 12'h108;
  localparam logic [11:0] OFF_LPA = 12'h10A;
  localparam logic [11:0] OFF_EXP = 12'h10C;

  // Advertisement layout
  localparam logic [15:0] ADV_WR_MASK = 16'hADFF;
  localparam logic [15:0] ADV_RST_BASE = 16'h01E1;
  localparam logic [15:0] ADV_RO_MASK = 16'h5200;
  localparam int ADV_NP_BIT = 15;
  localparam int ADV_RF_BIT = 13;
  localparam int ADV_PAUSE_LSB = 10;
  localparam int ADV_PAUSE_MSB = 11;
  localparam logic [3:0] ADV_ABIL_RST = 4'hF;
  localparam int ADV_ABIL_LSB = 5;
  localparam int ADV_ABIL_MSB = 8;
  localparam logic [4:0] ADV_SEL_8023 = 5'h01;

  // Expansion status layout
  localparam int LPA_NP_BIT = 15;
  localparam int EXP_PDF_BIT = 4;
  localparam int EXP_LPNP_BIT = 3;
  localparam int EXP_NPA_BIT = 2;
  localparam int EXP_PRX_BIT = 1;
  localparam int EXP_LPAN_BIT = 0;
  localparam logic [15:0] EXP_RSVD_MASK = 16'hFFE0;

  // Register selected by an access
  typedef enum logic [2:0] {
    PAB_REG_NONE = 3'b000,
    PAB_REG_ID_HI = 3'b001,
    PAB_REG_ID_LO = 3'b010,
    PAB_REG_ADV = 3'b011,
    PAB_REG_LPA = 3'b100,
    PAB_REG_EXP = 3'b101
  } pab_reg_e;

endpackage

// ===== verification/pab_lp_model.sv
// Far-side link partner: turns bench requests into one-cycle page strobes
module pab_lp_model (
  input logic sys_clk,
  input logic [4:0] req_page,
  input logic [15:0] req_word,
  input logic [4:0] req_fault,
  input logic [4:0] req_able,
  output logic [4:0] lp_page_valid,
  output logic [4:0][15:0] lp_page_word,
  output logic [4:0] par_det_fault,
  output logic [4:0] lp_an_able
);
  timeunit 1ns;
  timeprecision 1ps;
  // Outside a page the word shows the inverse of the last one sent,
  // so a design that samples without the strobe picks up garbage
  always_ff @(posedge sys_clk) begin
    lp_page_valid <= req_page;
    par_det_fault <= req_fault;
    lp_an_able <= req_able;
    for (int i = 0; i < 5; i++) begin
      lp_page_word[i] <= req_page[i] ? req_word : ~req_word;
    end
  end
endmodule // pab_lp_model

// ===== verification/phy_autoneg_id_register_bank_tb.sv
module phy_autoneg_id_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ID_HI = 16'h5A69; // Arbitrary value
  localparam logic [15:0] ID_LO = 16'h0C3E; // Arbitrary value
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic strap = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata_r;
  logic reg_rvalid_r;
  logic [4:0] req_page = 5'h00;
  logic [4:0] req_fault = 5'h00;
  logic [4:0] req_able = 5'h00;
  logic [15:0] req_word = 16'h0000;
  logic [4:0] lp_page_valid;
  logic [4:0][15:0] lp_page_word;
  logic [4:0] par_det_fault;
  logic [4:0] lp_an_able;
  logic [4:0][15:0] adv_word_r;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  integer seed = 32'hEC059077;
  logic [15:0] w;
  logic [15:0] e;
  pab_reg_bank #(.ID_HI_VALUE(ID_HI), .ID_LO_VALUE(ID_LO)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .pause_default_strap_pin(strap),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .lp_page_valid(lp_page_valid),
    .lp_page_word(lp_page_word), .par_det_fault(par_det_fault),
    .lp_an_able(lp_an_able), .adv_word_r(adv_word_r));
  pab_lp_model i_lp (
    .sys_clk(sys_clk), .req_page(req_page), .req_word(req_word),
    .req_fault(req_fault), .req_able(req_able),
    .lp_page_valid(lp_page_valid), .lp_page_word(lp_page_word),
    .par_det_fault(par_det_fault), .lp_an_able(lp_an_able));
  // 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] x);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  function automatic logic [15:0] adr(input int p, input logic [11:0] o);
    return {p[3:0], o};
  endfunction
  // Expansion word as it should read: reserved zero, bit 2 always one
  function automatic logic [15:0] expw(input logic f, input logic np,
                                       input logic pr, input logic ab);
    return {11'h000, f, np, 1'b1, pr, ab};
  endfunction
  // Read answers exactly one cycle after the strobe edge
  task rd(input logic [15:0] a, input logic [15:0] x);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({15'h0000, reg_rvalid_r}, 16'h0001);
    chk(reg_rdata_r, x);
    // Answer stands one cycle only, data back to zero after it
    @(posedge sys_clk);
    #1;
    chk({15'h0000, reg_rvalid_r}, 16'h0000);
    chk(reg_rdata_r, 16'h0000);
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Page or fault event; the model adds one cycle before the design
  task send(input int p, input logic [15:0] d, input logic f);
    @(posedge sys_clk);
    req_able <= 5'($random(seed));
    if (f) begin
      req_fault[p-1] <= 1'b1;
    end else begin
      req_page[p-1] <= 1'b1;
      req_word <= d;
    end
    @(posedge sys_clk);
    req_page <= 5'h00;
    req_fault <= 5'h00;
    @(posedge sys_clk);
  endtask
  // Reset with a given strap level, then check every port's defaults
  task do_reset(input logic s);
    @(posedge sys_clk);
    srst <= 1'b1;
    strap <= s;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    for (int p = 1; p <= 5; p++) begin
      e = {4'h0, s, s, 10'h1E1};
      rd(adr(p, pab_pkg::OFF_ADV), e);
      chk(adv_word_r[p-1], e);
      rd(adr(p, pab_pkg::OFF_LPA), 16'h0000);
      rd(adr(p, pab_pkg::OFF_EXP), 16'h0004);
    end
  endtask
  initial begin
    do_reset(1'b0);
    do_reset(1'b1);
    for (int p = 1; p <= 5; p++) begin
      wr(adr(p, pab_pkg::OFF_ID_HI), 16'($random(seed)));
      rd(adr(p, pab_pkg::OFF_ID_HI), ID_HI);
      wr(adr(p, pab_pkg::OFF_ID_LO), 16'($random(seed)));
      rd(adr(p, pab_pkg::OFF_ID_LO), ID_LO);
      // Every pause code, random other bits
      for (int k = 0; k < 4; k++) begin
        w = 16'($random(seed));
        w[11:10] = k[1:0];
        wr(adr(p, pab_pkg::OFF_ADV), w);
        e = w & pab_pkg::ADV_WR_MASK;
        rd(adr(p, pab_pkg::OFF_ADV), e);
        chk(adv_word_r[p-1], e);
      end
    end
    // Refused writes leave the word alone; unmapped reads give zero
    wr(adr(2, pab_pkg::OFF_ADV), 16'hFFFF);
    wr(16'h0108, 16'h0000);
    wr(16'h6108, 16'h0000);
    wr(adr(2, pab_pkg::OFF_LPA), 16'h0000);
    rd(adr(2, pab_pkg::OFF_ADV), 16'hADFF);
    rd(16'h0108, 16'h0000);
    rd(16'h2109, 16'h0000);
    rd(16'hF10C, 16'h0000);
    // Partner pages and latched flags, cleared by reading
    for (int p = 1; p <= 5; p++) begin
      w = (p == 1) ? 16'hE000 : 16'($random(seed));
      send(p, w, 1'b0);
      rd(adr(p, pab_pkg::OFF_LPA), w);
      e = expw(1'b0, w[15], 1'b1, req_able[p-1]);
      rd(adr(p, pab_pkg::OFF_EXP), e);
      e = expw(1'b0, w[15], 1'b0, req_able[p-1]);
      rd(adr(p, pab_pkg::OFF_EXP), e);
      send(p, w, 1'b1);
      e = expw(1'b1, w[15], 1'b0, req_able[p-1]);
      rd(adr(p, pab_pkg::OFF_EXP), e);
      e = expw(1'b0, w[15], 1'b0, req_able[p-1]);
      rd(adr(p, pab_pkg::OFF_EXP), e);
      // Page and fault land in the cycle of a read: the read sees the
      // old flags, and both flags are set afterwards
      @(posedge sys_clk);
      req_fault[p-1] <= 1'b1;
      req_page[p-1] <= 1'b1;
      req_word <= w;
      fork
        rd(adr(p, pab_pkg::OFF_EXP), e);
        begin
          @(posedge sys_clk);
          req_page <= 5'h00;
          req_fault <= 5'h00;
        end
      join
      e = expw(1'b1, w[15], 1'b1, req_able[p-1]);
      rd(adr(p, pab_pkg::OFF_EXP), e);
      e = expw(1'b0, w[15], 1'b0, req_able[p-1]);
      rd(adr(p, pab_pkg::OFF_EXP), e);
    end
    report_and_stop();
  end
endmodule // phy_autoneg_id_register_bank_tb
